// *** design/ddrh_pkg.sv ***
`default_nettype none
package ddrh_pkg;
    localparam real SYS_CLK_NS = 5.0;
    // The device clock is the system clock halved: 10 ns.
    localparam int CK_DIV = 2;
    localparam int BANKS = 4;
    localparam int BA_W = 2;
    localparam int ADDR_W = 13;
    localparam int AP_BIT = 10;
    localparam int CNT_W = 10;
    localparam real T_RCD_NS = 18.0;
    localparam real T_RP_NS = 18.0;
    localparam real T_RAS_NS = 42.0;
    localparam real T_RAS_MAX_NS = 120000.0;
    localparam real T_RC_NS = 60.0;
    localparam real T_RFC_NS = 72.0;
    localparam real T_RRD_NS = 12.0;
    localparam real T_WR_NS = 15.0;
    localparam real T_DAL_NS = 35.0;
    localparam real T_MRD_NS = 12.0;
    localparam real T_XSNR_NS = 75.0;
    localparam real T_REFI_US = 7.8;
    localparam int T_WTR_TCK = 1;
    localparam int T_XSRD_TCK = 200;
    localparam int T_XP_TCK = 1;
    localparam int T_XPRD_SLOW_TCK = 200;
    localparam int REF_POST_MAX = 8;
    function automatic int cyc_min(real ns);
        int c;
        c = int'($ceil(ns / SYS_CLK_NS));
        return (c < 1) ? 1 : c;
    endfunction : cyc_min
    function automatic int cyc_max(real ns);
        int c;
        c = int'($floor(ns / SYS_CLK_NS));
        return (c < 1) ? 1 : c;
    endfunction : cyc_max
    function automatic logic [CNT_W-1:0] cv(int v);
        return CNT_W'(v);
    endfunction : cv
    localparam int C_RCD = cyc_min(T_RCD_NS);
    localparam int C_RP = cyc_min(T_RP_NS);
    localparam int C_RAS = cyc_min(T_RAS_NS);
    localparam int C_RAS_MAX = cyc_max(T_RAS_MAX_NS);
    localparam int C_RC = cyc_min(T_RC_NS);
    localparam int C_RFC = cyc_min(T_RFC_NS);
    localparam int C_RRD = cyc_min(T_RRD_NS);
    localparam int C_WR = cyc_min(T_WR_NS);
    localparam int C_DAL = cyc_min(T_DAL_NS);
    localparam int C_MRD = cyc_min(T_MRD_NS);
    localparam int C_XSNR = cyc_min(T_XSNR_NS);
    localparam int C_REFI = cyc_max(T_REFI_US * 1000.0);
    localparam int C_WTR = T_WTR_TCK * CK_DIV;
    localparam int C_XSRD = T_XSRD_TCK * CK_DIV;
    localparam int C_XP = T_XP_TCK * CK_DIV;
    localparam int C_XPRD_SLOW = T_XPRD_SLOW_TCK * CK_DIV;
    localparam int C_WDONE = 5;
    localparam int C_RAS_GUARD = 16;
    localparam int C_RD_TMO = 24;
    localparam int REFI_W = $clog2(C_REFI + 1);
    localparam logic [2:0] CODE_MRS = 3'h0;
    localparam logic [2:0] CODE_REF = 3'h1;
    localparam logic [2:0] CODE_PRE = 3'h2;
    localparam logic [2:0] CODE_ACT = 3'h3;
    localparam logic [2:0] CODE_WR = 3'h4;
    localparam logic [2:0] CODE_RD = 3'h5;
    localparam logic [2:0] CODE_NOP = 3'h7;
    typedef enum logic [3:0] {
        OP_NOP, OP_ACT, OP_RD, OP_WR, OP_PRE, OP_PREA,
        OP_REF, OP_MRS, OP_SRE, OP_SRX, OP_PDE, OP_PDX
    } ddrh_op_t;
    typedef enum logic [1:0] {PS_ACTIVE, PS_SELF, PS_PDOWN} ddrh_pwr_t;
    typedef struct packed {
        ddrh_op_t op;
        logic [BA_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
    } ddrh_req_t;
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic [2:0] code;
        logic [BA_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
    } ddrh_pin_t;
    localparam ddrh_pin_t PIN_IDLE = '{1'b1, 1'b1, CODE_NOP, 2'h0, 13'h0};
endpackage : ddrh_pkg
`default_nettype wire

// *** design/ddrh_ctrl.sv ***
`default_nettype none
// Overview of operation
// - Activate to read/write at least 18 ns.
// - Precharge to activate at least 18 ns.
// - Row open between 42 ns and 120 us; power-down keeps a stale row open until exit.
// - Activate to activate or refresh 60 ns.
// - Refresh to activate or refresh 72 ns.
// - Activates to different banks 12 ns apart.
// - Write recovery 15 ns, auto-precharge 35 ns.
// - One clock from write end to read.
// - Self refresh exit to non-read 75 ns.
// - Self refresh exit to read 200 clocks.
// - Power-down exit to command one clock.
// - Unstable clock: read waits 200 clocks.
// - Average refresh interval at most 7.8 us.
// - At most eight refreshes owed.
// - Mode register set to next 12 ns.
// - First strobe rise 0.75-1.25 clocks after write.
// - Strobe valid, low preamble 0.25 clock.
// - Strobe leaves high impedance going low.
// - Write postamble 0.4 to 0.6 clock.
// - Address bit ten selects auto precharge.
module ddrh_ctrl #(
    parameter int DQ_W = 64,
    parameter int DM_W = 8,
    parameter int RAS_MAX_CYC = ddrh_pkg::C_RAS_MAX
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire ddrh_pkg::ddrh_req_t req,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [2*DQ_W-1:0] wr_data,
    input wire logic [2*DM_W-1:0] wr_mask,
    output logic [2*DQ_W-1:0] rd_data,
    output logic rd_valid,
    input wire logic clk_unstable,
    output logic [3:0] ref_owed,
    output logic ddr_ck,
    output logic ddr_ck_n,
    output var ddrh_pkg::ddrh_pin_t ddr_cmd,
    output logic [DQ_W-1:0] dq_o,
    output logic dq_oe,
    input wire logic [DQ_W-1:0] dq_i,
    output logic [DM_W-1:0] dm_o,
    output logic dqs_o,
    output logic dqs_oe,
    input wire logic dqs_i
);
    import ddrh_pkg::*;

    localparam int OPEN_W = $clog2(RAS_MAX_CYC + 1);
    localparam logic [OPEN_W-1:0] AGE_LIM = OPEN_W'(RAS_MAX_CYC - C_RAS_GUARD);

    typedef struct packed {
        logic ck;
        logic ckn;
        ddrh_pin_t cmd;
        logic ready;
        ddrh_pwr_t pwr;
        logic unstable;
        logic [BANKS-1:0] open;
        logic [BANKS-1:0][CNT_W-1:0] rcd;
        logic [BANKS-1:0][CNT_W-1:0] ras;
        logic [BANKS-1:0][CNT_W-1:0] rc;
        logic [BANKS-1:0][CNT_W-1:0] wr;
        logic [BANKS-1:0][OPEN_W-1:0] age;
        logic [CNT_W-1:0] rrd;
        logic [CNT_W-1:0] mrd;
        logic [CNT_W-1:0] wtr;
        logic [CNT_W-1:0] nonrd;
        logic [CNT_W-1:0] rdw;
        logic [REFI_W-1:0] refi;
        logic [3:0] owed;
        logic [2:0] wseq;
        logic [2*DQ_W-1:0] wbuf;
        logic [2*DM_W-1:0] wm;
        logic dq_oe;
        logic [DQ_W-1:0] dq;
        logic [DM_W-1:0] dm;
        logic dqs;
        logic dqs_oe;
        logic [DQ_W-1:0] dq_m;
        logic [DQ_W-1:0] dq_s;
        logic dqs_m;
        logic dqs_s;
        logic dqs_d;
        logic rd_open;
        logic rd_word;
        logic [CNT_W-1:0] rd_tmo;
        logic [2*DQ_W-1:0] rdata;
        logic rvalid;
    } ddrh_state_t;

    ddrh_state_t st;
    ddrh_state_t nx;
    logic any_open;
    logic all_rc_ok;
    logic all_pre_ok;
    logic stale;
    logic [BA_W-1:0] stale_ba;
    logic force_ref;
    logic nr_ok;
    logic ok;
    logic user;
    logic did_ref;
    ddrh_op_t op;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] ad;

    function automatic logic [CNT_W-1:0] dec(logic [CNT_W-1:0] v);
        return (v == '0) ? v : v - 1'b1;
    endfunction : dec

    function automatic logic [CNT_W-1:0] cmax(logic [CNT_W-1:0] a, logic [CNT_W-1:0] b);
        return (a > b) ? a : b;
    endfunction : cmax

    always_comb begin
        nx = st;
        any_open = |st.open;
        all_rc_ok = 1'b1;
        all_pre_ok = 1'b1;
        stale = 1'b0;
        stale_ba = '0;
        did_ref = 1'b0;
        user = 1'b0;
        ok = 1'b0;
        nx.ck = ~st.ck;
        nx.ckn = st.ck;
        nx.ready = 1'b0;
        nx.rvalid = 1'b0;
        for (int b = 0; b < BANKS; b++) begin
            if (st.rc[b] != '0) all_rc_ok = 1'b0;
            if (st.open[b] && (st.ras[b] != '0 || st.wr[b] != '0)) all_pre_ok = 1'b0;
            if (st.open[b] && st.age[b] >= AGE_LIM && !stale) begin
                stale = 1'b1;
                stale_ba = BA_W'(b);
            end
            nx.rcd[b] = dec(st.rcd[b]);
            nx.ras[b] = dec(st.ras[b]);
            nx.rc[b] = dec(st.rc[b]);
            nx.wr[b] = dec(st.wr[b]);
            if (!st.open[b]) nx.age[b] = '0;
            else if (st.age[b] < AGE_LIM) nx.age[b] = OPEN_W'(st.age[b] + 1'b1);
        end
        nx.rrd = dec(st.rrd);
        nx.mrd = dec(st.mrd);
        nx.wtr = dec(st.wtr);
        nx.nonrd = dec(st.nonrd);
        nx.rdw = dec(st.rdw);
        force_ref = st.owed >= 4'(REF_POST_MAX);
        nr_ok = st.nonrd == '0;
        // Read words are caught on each strobe toggle; the fixed latency of the
        // synchronisers applies to strobe and data alike.
        nx.dq_m = dq_i;
        nx.dq_s = st.dq_m;
        nx.dqs_m = dqs_i;
        nx.dqs_s = st.dqs_m;
        nx.dqs_d = st.dqs_s;
        if (st.rd_open) begin
            nx.rd_tmo = dec(st.rd_tmo);
            if (st.dqs_s != st.dqs_d) begin
                if (!st.rd_word) begin
                    nx.rdata[DQ_W-1:0] = st.dq_s;
                    nx.rd_word = 1'b1;
                end else begin
                    nx.rdata[2*DQ_W-1:DQ_W] = st.dq_s;
                    nx.rd_open = 1'b0;
                    nx.rvalid = 1'b1;
                end
            end else if (st.rd_tmo == '0) begin
                nx.rd_open = 1'b0;
            end
        end
        // The write command reaches the device at the rising clock one cycle
        // after issue; strobe and data follow on the system clock grid.
        unique case (st.wseq)
            3'h0: nx.wseq = 3'h0;
            3'h1: nx.wseq = 3'h2;
            3'h2: begin
                nx.wseq = 3'h3;
                nx.dqs_oe = 1'b1;
                nx.dqs = 1'b0;
                nx.dq_oe = 1'b1;
                nx.dq = st.wbuf[DQ_W-1:0];
                nx.dm = st.wm[DM_W-1:0];
            end
            3'h3: begin
                nx.wseq = 3'h4;
                nx.dqs = 1'b1;
            end
            3'h4: begin
                nx.wseq = 3'h5;
                nx.dqs = 1'b0;
                nx.dq = st.wbuf[2*DQ_W-1:DQ_W];
                nx.dm = st.wm[2*DM_W-1:DM_W];
            end
            3'h5: begin
                nx.wseq = 3'h0;
                nx.dqs_oe = 1'b0;
                nx.dq_oe = 1'b0;
            end
            default: nx.wseq = 3'h0;
        endcase
        if (st.pwr == PS_PDOWN) nx.unstable = st.unstable | clk_unstable;
        op = OP_NOP;
        ba = req.bank;
        ad = req.addr;
        if (force_ref) op = any_open ? OP_PREA : OP_REF;
        else if (stale) begin
            op = OP_PRE;
            ba = stale_ba;
        end else if (req_valid) begin
            op = req.op;
            user = 1'b1;
        end
        // Commands change as the clock falls so they are stable at its rise.
        if (st.ck) begin
            nx.cmd = '{st.cmd.cke, 1'b0, CODE_NOP, 2'h0, 13'h0};
            unique case (st.pwr)
                PS_SELF: begin
                    if (req_valid && req.op == OP_SRX) begin
                        nx.cmd.cke = 1'b1;
                        nx.pwr = PS_ACTIVE;
                        nx.nonrd = cv(C_XSNR);
                        nx.rdw = cv(C_XSRD);
                        nx.ready = 1'b1;
                    end
                end
                PS_PDOWN: begin
                    if (force_ref || (req_valid && req.op == OP_PDX)) begin
                        nx.cmd.cke = 1'b1;
                        nx.pwr = PS_ACTIVE;
                        nx.nonrd = cv(C_XP);
                        nx.rdw = (st.unstable | clk_unstable) ? cv(C_XPRD_SLOW) : cv(C_XP);
                        nx.ready = req_valid && req.op == OP_PDX;
                    end
                end
                PS_ACTIVE: begin
                    unique case (op)
                        OP_NOP, OP_SRX, OP_PDX: ok = 1'b1;
                        OP_ACT: ok = nr_ok && !st.open[ba] && st.rc[ba] == '0 && st.rrd == '0;
                        OP_RD: ok = st.open[ba] && st.rcd[ba] == '0 && st.wtr == '0 && st.rdw == '0
                            && !st.rd_open && st.wseq == '0;
                        OP_WR: ok = nr_ok && st.open[ba] && st.rcd[ba] == '0 && !st.rd_open
                            && st.wseq == '0;
                        OP_PRE: ok = nr_ok && st.ras[ba] == '0 && st.wr[ba] == '0;
                        OP_PREA: ok = nr_ok && all_pre_ok;
                        OP_REF, OP_SRE: ok = nr_ok && !any_open && all_rc_ok;
                        OP_MRS: ok = nr_ok && !any_open;
                        OP_PDE: ok = nr_ok;
                    endcase
                    if (st.mrd != '0) ok = 1'b0;
                    if (ok) begin
                        nx.ready = user;
                        unique case (op)
                            OP_NOP, OP_SRX, OP_PDX: nx.ready = user;
                            OP_ACT: begin
                                nx.cmd = '{1'b1, 1'b0, CODE_ACT, ba, ad};
                                nx.open[ba] = 1'b1;
                                nx.rcd[ba] = cv(C_RCD);
                                nx.ras[ba] = cv(C_RAS);
                                nx.rc[ba] = cv(C_RC);
                                nx.rrd = cv(C_RRD);
                            end
                            OP_RD: begin
                                nx.cmd = '{1'b1, 1'b0, CODE_RD, ba, ad};
                                nx.rd_open = 1'b1;
                                nx.rd_word = 1'b0;
                                nx.rd_tmo = cv(C_RD_TMO);
                                if (ad[AP_BIT]) begin
                                    nx.open[ba] = 1'b0;
                                    nx.rc[ba] = cmax(st.rc[ba], CNT_W'(st.ras[ba] + cv(C_RP)));
                                end
                            end
                            OP_WR: begin
                                nx.cmd = '{1'b1, 1'b0, CODE_WR, ba, ad};
                                nx.wseq = 3'h1;
                                nx.wbuf = wr_data;
                                nx.wm = wr_mask;
                                nx.wtr = cv(C_WDONE + C_WTR);
                                if (ad[AP_BIT]) begin
                                    nx.open[ba] = 1'b0;
                                    nx.rc[ba] = cmax(st.rc[ba], cv(C_WDONE + C_DAL));
                                end else begin
                                    nx.wr[ba] = cv(C_WDONE + C_WR);
                                end
                            end
                            OP_PRE: begin
                                ad[AP_BIT] = 1'b0;
                                nx.cmd = '{1'b1, 1'b0, CODE_PRE, ba, ad};
                                nx.open[ba] = 1'b0;
                                nx.rc[ba] = cmax(st.rc[ba], cv(C_RP));
                            end
                            OP_PREA: begin
                                ad[AP_BIT] = 1'b1;
                                nx.cmd = '{1'b1, 1'b0, CODE_PRE, ba, ad};
                                nx.open = '0;
                                for (int b = 0; b < BANKS; b++) nx.rc[b] = cmax(st.rc[b], cv(C_RP));
                            end
                            OP_REF: begin
                                nx.cmd = '{1'b1, 1'b0, CODE_REF, ba, ad};
                                for (int b = 0; b < BANKS; b++) nx.rc[b] = cv(C_RFC);
                                did_ref = 1'b1;
                            end
                            OP_SRE: begin
                                nx.cmd = '{1'b0, 1'b0, CODE_REF, ba, ad};
                                nx.pwr = PS_SELF;
                            end
                            OP_MRS: begin
                                nx.cmd = '{1'b1, 1'b0, CODE_MRS, ba, ad};
                                nx.mrd = cv(C_MRD);
                            end
                            OP_PDE: begin
                                nx.cmd.cke = 1'b0;
                                nx.pwr = PS_PDOWN;
                                nx.unstable = 1'b0;
                            end
                        endcase
                    end
                end
            endcase
        end
        // Self refresh keeps the array alive, so the backlog is forgiven there.
        if (st.pwr == PS_SELF) begin
            nx.refi = REFI_W'(C_REFI - 1);
            nx.owed = '0;
        end else begin
            nx.refi = (st.refi == '0) ? REFI_W'(C_REFI - 1) : REFI_W'(st.refi - 1'b1);
            // The count saturates at the posting limit and never wraps below zero,
            // so a refresh issued ahead of schedule earns no credit.
            if (st.refi == '0 && !did_ref && st.owed != 4'(REF_POST_MAX)) begin
                nx.owed = st.owed + 4'h1;
            end else if (st.refi != '0 && did_ref && st.owed != '0) begin
                nx.owed = st.owed - 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
            st.cmd <= PIN_IDLE;
            st.refi <= REFI_W'(C_REFI - 1);
        end else begin
            st <= nx;
        end
    end

    assign req_ready = st.ready;
    assign rd_data = st.rdata;
    assign rd_valid = st.rvalid;
    assign ref_owed = st.owed;
    assign ddr_ck = st.ck;
    assign ddr_ck_n = st.ckn;
    assign ddr_cmd = st.cmd;
    assign dq_o = st.dq;
    assign dq_oe = st.dq_oe;
    assign dm_o = st.dm;
    assign dqs_o = st.dqs;
    assign dqs_oe = st.dqs_oe;

    // Pin-side observers for the checks below.
    logic pin_new;
    logic pin_act;
    logic pin_rd;
    logic pin_rw;
    logic pin_ref;
    logic [15:0] h_act_age;
    logic [BA_W-1:0] h_act_ba;
    logic [15:0] h_ref_age;
    logic [15:0] h_srx_age;
    logic h_in_sr;
    // Selected no-operation cycles fill every gap, so they do not count as commands.
    assign pin_new = !ddr_ck && !ddr_cmd.cs_n && ddr_cmd.code != CODE_NOP;
    assign pin_act = pin_new && ddr_cmd.code == CODE_ACT;
    assign pin_rd = pin_new && ddr_cmd.code == CODE_RD;
    assign pin_rw = pin_rd || (pin_new && ddr_cmd.code == CODE_WR);
    assign pin_ref = pin_new && ddr_cmd.code == CODE_REF && ddr_cmd.cke;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            h_act_age <= 16'hFFFF;
            h_act_ba <= 2'h0;
            h_ref_age <= 16'hFFFF;
            h_srx_age <= 16'hFFFF;
            h_in_sr <= 1'b0;
        end else begin
            h_act_age <= pin_act ? 16'h1 : ((&h_act_age) ? h_act_age : h_act_age + 16'h1);
            h_ref_age <= pin_ref ? 16'h1 : ((&h_ref_age) ? h_ref_age : h_ref_age + 16'h1);
            h_srx_age <= (&h_srx_age) ? h_srx_age : h_srx_age + 16'h1;
            if (pin_act) h_act_ba <= ddr_cmd.ba;
            if (pin_new && ddr_cmd.code == CODE_REF && !ddr_cmd.cke) h_in_sr <= 1'b1;
            if (h_in_sr && ddr_cmd.cke) begin
                h_in_sr <= 1'b0;
                h_srx_age <= 16'h1;
            end
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_rcd;
        pin_rw && ddr_cmd.ba == h_act_ba |-> h_act_age >= C_RCD;
    endproperty
    a_rcd: assert property (p_rcd) else $error("read or write too soon after activate");
    property p_rfc;
        pin_act || pin_ref |-> h_ref_age >= C_RFC;
    endproperty
    a_rfc: assert property (p_rfc) else $error("command too soon after refresh");
    property p_mrd;
        pin_new && ddr_cmd.code == CODE_MRS |=> !pin_new [*3];
    endproperty
    a_mrd: assert property (p_mrd) else $error("command too soon after mode set");
    property p_wr_strobe;
        pin_new && ddr_cmd.code == CODE_WR |-> ##2 (dqs_oe && !dqs_o) ##1 (dqs_oe && dqs_o);
    endproperty
    a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe misplaced");
    property p_preamble;
        $rose(dqs_oe) |-> !dqs_o ##1 (dqs_oe && dqs_o);
    endproperty
    a_preamble: assert property (p_preamble) else $error("preamble not low");
    property p_postamble;
        dqs_oe && $fell(dqs_o) |=> !dqs_oe;
    endproperty
    a_postamble: assert property (p_postamble) else $error("postamble length wrong");
    property p_owed;
        ref_owed <= 4'(REF_POST_MAX);
    endproperty
    a_owed: assert property (p_owed) else $error("too many refreshes owed");
    property p_xsrd;
        pin_rd |-> h_srx_age >= C_XSRD;
    endproperty
    a_xsrd: assert property (p_xsrd) else $error("read too soon after self refresh");
    property p_ap;
        pin_rw && ddr_cmd.addr[AP_BIT] |-> !st.open[ddr_cmd.ba];
    endproperty
    a_ap: assert property (p_ap) else $error("auto precharge left bank open");

    c_write: cover property (pin_new && ddr_cmd.code == CODE_WR ##[1:8] $fell(dqs_oe));
    c_read: cover property (rd_valid);
    c_force_ref: cover property (ref_owed == 4'(REF_POST_MAX) ##[1:64] pin_ref);
    c_srx: cover property (h_in_sr ##1 !h_in_sr);
endmodule : ddrh_ctrl
`default_nettype wire

// *** test/ddrh_dev_model.sv ***
`default_nettype none
module ddrh_dev_model
    import ddrh_pkg::*;
(
    input wire logic ck,
    input wire ddrh_pkg::ddrh_pin_t cmd,
    input wire logic [63:0] dq_o,
    input wire logic dqs_o,
    input wire logic dqs_oe,
    input wire logic dq_oe,
    input wire logic ck_n,
    input wire logic [7:0] dm_o,
    input wire logic uns_in,
    output logic [63:0] dq_i = '0,
    output logic dqs_i = 1'b0,
    output int viol = 0,
    output int n_ref = 0,
    output logic [127:0] wd,
    output logic [15:0] wm
);
    timeunit 1ns;
    timeprecision 100ps;
    realtime ta[4] = '{4{-1e6}}, tp[4] = '{4{-1e6}};
    realtime tr = -1e6, tx = -1e6, tw = -1e6, tm = -1e6, tq, tf, t;
    logic sr = 0, srx = 0, un = 0, ke = 1;
    // The strobe line is terminated, so it rests low once released.
    task automatic reply(logic [12:0] a);
        // Replies start off the system clock edge so that capture never races them.
        #21 dq_i = {4{3'h0, a}};
        dqs_i = 1'b1;
        #10 dq_i = ~{4{3'h0, a}};
        dqs_i = 1'b0;
        #10 dq_i = {4{3'h0, a}};
    endtask : reply
    always @(posedge ck) begin
        t = $realtime;
        if (!cmd.cke) un = (ke ? 1'b0 : un) | uns_in;
        if (!cmd.cke && ke) sr = !cmd.cs_n && cmd.code == CODE_REF;
        if (cmd.cke && !ke) begin
            tx = t;
            srx = sr;
        end
        if (cmd.cke && ke && !cmd.cs_n && cmd.code != CODE_NOP) begin
            if (t - tm < 12.0) viol++;
            if (srx && cmd.code != CODE_RD && t - tx < 75.0) viol++;
            if (cmd.code == CODE_RD && t - tx < ((srx || un) ? 2000.0 : 10.0)) viol++;
            case (cmd.code)
                CODE_MRS: tm = t;
                CODE_REF: begin
                    if (t - tr < 72.0) viol++;
                    tr = t;
                    n_ref++;
                end
                CODE_ACT: begin
                    if (t - tp[cmd.ba] < 18.0 || t - tr < 72.0) viol++;
                    ta[cmd.ba] = t;
                end
                CODE_PRE: begin
                    if (!cmd.addr[AP_BIT] && t - ta[cmd.ba] < 42.0) viol++;
                    tp[cmd.ba] = t;
                end
                CODE_RD, CODE_WR: begin
                    if (t - ta[cmd.ba] < 18.0) viol++;
                    if (cmd.addr[AP_BIT]) tp[cmd.ba] = t;
                    if (cmd.code == CODE_WR) tw = t;
                    else fork reply(cmd.addr); join_none
                end
                default: ;
            endcase
        end
        ke = cmd.cke;
    end
    always @(posedge dqs_oe) begin
        tq = $realtime;
        #1 if (dqs_o !== 1'b0) viol++;
    end
    always @(posedge dqs_o) begin
        if ($realtime - tq < 2.5) viol++;
        if ($realtime - tw < 7.5 || $realtime - tw > 12.5) viol++;
        if (dq_oe !== 1'b1) viol++;
        #1 {wm[7:0], wd[63:0]} = {dm_o, dq_o};
    end
    always @(negedge dqs_o) begin
        tf = $realtime;
        #1 {wm[15:8], wd[127:64]} = {dm_o, dq_o};
    end
    always @(negedge dqs_oe) if (tw > 0 && $realtime - tf < 4.0) viol++;
    always @(ck) #1 if (cmd.cs_n === 1'b0 && ck_n !== !ck) viol++;
endmodule : ddrh_dev_model
`default_nettype wire

// *** test/ddrh_ctrl_tb.sv ***
`default_nettype none
module ddrh_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ddrh_pkg::*;
    logic sys_clk, sys_rst, req_valid, clk_unstable, req_ready, rd_valid, ddr_ck, ddr_ck_n;
    logic dq_oe, dqs_o, dqs_oe, dqs_i;
    logic [127:0] wr_data, rd_data, wd;
    logic [15:0] wr_mask, wm;
    logic [3:0] ref_owed;
    logic [63:0] dq_o, dq_i;
    logic [7:0] dm_o;
    logic [1:0] b;
    logic [12:0] a;
    ddrh_req_t req;
    ddrh_pin_t ddr_cmd;
    int viol, n_ref, r, seed = 32'h8204, n_mismatch = 0, comparisons = 0;
    ddrh_ctrl #(.RAS_MAX_CYC(600)) u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req),
        .req_valid(req_valid), .req_ready(req_ready), .wr_data(wr_data), .wr_mask(wr_mask),
        .rd_data(rd_data), .rd_valid(rd_valid), .clk_unstable(clk_unstable),
        .ref_owed(ref_owed), .ddr_ck(ddr_ck), .ddr_ck_n(ddr_ck_n), .ddr_cmd(ddr_cmd),
        .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .dm_o(dm_o), .dqs_o(dqs_o),
        .dqs_oe(dqs_oe), .dqs_i(dqs_i));
    ddrh_dev_model u_dev (.ck(ddr_ck), .cmd(ddr_cmd), .dq_o(dq_o), .dqs_o(dqs_o),
        .dqs_oe(dqs_oe), .dq_oe(dq_oe), .ck_n(ddr_ck_n), .dm_o(dm_o),
        .uns_in(clk_unstable), .dq_i(dq_i), .dqs_i(dqs_i), .viol(viol),
        .n_ref(n_ref), .wd(wd), .wm(wm));
    initial forever #2.5 sys_clk = ~sys_clk;
    function automatic logic [127:0] exp_rd(logic [12:0] ad);
        return {~{4{3'h0, ad}}, {4{3'h0, ad}}};
    endfunction : exp_rd
    task automatic chk(string nm, logic [127:0] e, logic [127:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    task automatic go(ddrh_op_t op, logic [1:0] bk, logic [12:0] ad);
        int k;
        @(posedge sys_clk) #1;
        req = '{op, bk, ad};
        req_valid = 1'b1;
        for (k = 0; k < 3000 && req_ready !== 1'b1; k++) @(posedge sys_clk) #1;
        req_valid = 1'b0;
        if (k == 3000) begin
            chk("request taken", 1, 0);
            tally_and_finish();
        end
    endtask : go
    task automatic rd(logic [1:0] bk, logic [12:0] ad);
        int k;
        go(OP_RD, bk, ad);
        for (k = 0; k < 60 && rd_valid !== 1'b1; k++) @(posedge sys_clk) #1;
        if (k == 60) begin
            chk("read valid", 1, 0);
            tally_and_finish();
        end
        chk("read data", exp_rd(ad), rd_data);
    endtask : rd
    task automatic wr(logic [1:0] bk, logic [12:0] ad);
        wr_data = {$random(seed), $random(seed), $random(seed), $random(seed)};
        wr_mask = 16'($random(seed));
        go(OP_WR, bk, ad);
        repeat (12) @(posedge sys_clk);
        chk("write words", wr_data, wd);
        chk("write mask", wr_mask, wm);
    endtask : wr
    initial begin
        {sys_clk, req_valid, clk_unstable, wr_data, wr_mask} = '0;
        sys_rst = 1'b1;
        req = '{OP_NOP, 2'h0, 13'h0};
        repeat (12) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        go(OP_PREA, 0, 0);
        go(OP_MRS, 0, 13'h0032);
        go(OP_REF, 0, 0);
        for (int i = 0; i < 30; i++) begin
            b = 2'($random(seed));
            a = 13'($random(seed));
            r = $random(seed);
            go(OP_ACT, b, a);
            if (r[0]) rd(b, a);
            else wr(b, a);
            if (!a[AP_BIT]) go(OP_PRE, b, 13'h0);
        end
        $display("test random traffic done");
        go(OP_ACT, 2, 0);
        repeat (700) @(posedge sys_clk);
        go(OP_ACT, 2, 0);
        go(OP_PRE, 2, 0);
        $display("test row age limit done");
        go(OP_ACT, 3, 0);
        clk_unstable = 1'b1;
        go(OP_PDE, 0, 0);
        go(OP_PDX, 0, 0);
        clk_unstable = 1'b0;
        rd(3, 13'h0155);
        go(OP_PRE, 3, 0);
        $display("test power down done");
        go(OP_SRE, 0, 0);
        go(OP_SRX, 0, 0);
        go(OP_ACT, 0, 0);
        rd(0, 13'h0AAA);
        go(OP_PRE, 0, 0);
        $display("test self refresh done");
        repeat (1300) @(posedge sys_clk) #1;
        chk("owed after one interval", 1, ref_owed);
        go(OP_REF, 0, 0);
        chk("owed after refresh", 0, ref_owed);
        r = n_ref;
        repeat (12600) @(posedge sys_clk) #1;
        chk("owed after forced refresh", 7, ref_owed);
        chk("forced refresh seen", 1, n_ref > r);
        $display("test refresh done");
        chk("device timing faults", 0, viol);
        tally_and_finish();
    end
endmodule : ddrh_ctrl_tb
`default_nettype wire
